/* shared/evt_timer_map.svh */
`ifndef EVT_TIMER_MAP_SVH
`define EVT_TIMER_MAP_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define IDX_TIMER_CONTROL   12'h100
`define IDX_PIN_CONTROL     12'h101
`define IDX_MODE_SELECT     12'h102
`define IDX_PRESCALE        12'h103
`define IDX_MAIN_COUNT      12'h104

// ************************************************************
// Field positions
// ************************************************************
`define CTL_START_BIT       0
`define CTL_STATUS_BIT      1
`define CTL_STOP_BIT        2
`define CTL_EDGE_BIT        4
`define CTL_UNDER_BIT       5
`define PIN_POLARITY_BIT    0
`define PIN_STORED_MASK     8'h3f
`define MODE_LSB            0
`define MODE_MSB            2
`define SRC_LSB             4
`define SRC_MSB             6
`define CUTOFF_BIT          7

// ************************************************************
// Codes and reset values
// ************************************************************
`define MODE_EVENT_COUNT    3'h2
`define MODE_PULSE_PERIOD   3'h3
`define RST_MODE_SELECT     8'h00
`define RST_PIN_CONTROL     8'h00
`define RST_COUNTER         8'hff
`define STOP_LOAD_VALUE     8'hff

`endif

/* shared/evt_timer_pkg.sv */
package evt_timer_pkg;

   // Start/stop synchronisation of the count status
   typedef enum logic [1:0] {
      RUN_STOPPED,
      RUN_START_SYNC,
      RUN_COUNTING,
      RUN_STOP_SYNC
   } run_state_t;

   typedef logic [7:0] byte_t;

endpackage

/* design/reload_down_counter.sv */
module reload_down_counter
   import evt_timer_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   // Load controls
   input  wire logic             force_load,
   input  wire logic [WIDTH-1:0] force_val,
   input  wire logic             wr_en,
   input  wire logic             wr_count,
   input  wire logic [WIDTH-1:0] wr_val,
   // Counting
   input  wire logic             dec,
   output logic      [WIDTH-1:0] count,
   output logic                  underflow
);

   logic [WIDTH-1:0] reload_ff;
   logic [WIDTH-1:0] count_ff;

   // Underflow is the decrement that passes zero
   assign underflow = dec && (count_ff == '0);
   assign count     = count_ff;

   // Reload value follows the last software write or forced load
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reload_ff <= {WIDTH{1'b1}};
      end else if (ce) begin
         if (force_load) begin
            reload_ff <= force_val;
         end else if (wr_en) begin
            reload_ff <= wr_val;
         end
      end
   end

   // Current count; a write only reaches it while stopped
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         count_ff <= {WIDTH{1'b1}};
      end else if (ce) begin
         if (force_load) begin
            count_ff <= force_val;
         end else if (wr_en && wr_count) begin
            count_ff <= wr_val;
         end else if (underflow) begin
            count_ff <= reload_ff;
         end else if (dec) begin
            count_ff <= count_ff - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule

/* design/event_counter_timer.sv */
// Summary of operation
// - Mode field value 010 selects event counter operation.
// - Mode register at index 0102h, reset 00h, mode 2..0, source 6..4, bit3 zero.
// - Count source reaches counters only while the cutoff bit is 0.
// - Forced stop loads the prescaler with FFh and halts counting.
// - Main counter at index 0104h, reset FFh, decrements per prescaler underflow.
// - Underflow every (prescaler+1)*(main+1) counted events.
// - With start set in event mode, pin edges are counted.
// - After reset the timer is stopped.
// - Each counter is read as its own byte; values may change between reads.
// - Pulse period mode: writing 0 clears edge or underflow flag, 1 keeps.
// - Flags undefined entering pulse period mode; software clears them first.
// - First prescaler underflow after start may set the edge flag.
// - Status stays 0 up to one cycle after start, then counting begins.
// - Status stays 1 up to one cycle after stop, then counting halts; the code halts counting as the stop sync cycle begins, status still 1.
// - Status flag reads 1 while counting, 0 while stopped; writes ignored.
// - Forced stop halts at once and always reads back 0.
// - Polarity bit 0 counts rising edges of the input pin.
//
// Register access over APB was left to the implementer.
`include "evt_timer_map.svh"

module event_counter_timer
   import evt_timer_pkg::*;
#(
   parameter int AW = 12
) (
   // Clock, reset, enable
   input  wire logic          CLK,
   input  wire logic          RST_B,
   input  wire logic          CE,
   // APB slave
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [AW-1:0] PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic      [31:0]   PRDATA,
   output logic               PREADY,
   output logic               PSLVERR,
   // Timer pin and request
   input  wire logic          TIMER_IO_PIN,
   output logic               TIMER_IRQ
);

   // ************************************************************
   // Declarations
   // ************************************************************
   run_state_t  run_ff;
   run_state_t  nxt_run;
   byte_t       mode_ff;
   byte_t       pin_ctl_ff;
   logic        start_ff;
   logic        edge_flag_ff;
   logic        under_flag_ff;
   logic        pin_prev_ff;
   logic        irq_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        setup_phase;
   logic        wr_take;
   logic        status;
   logic        counting;
   logic        event_mode;
   logic        pulse_mode;
   logic        pin_edge;
   logic        force_stop;
   logic        wr_presc;
   logic        wr_main;
   logic        presc_under;
   logic        main_under;
   byte_t       presc_count;
   byte_t       main_count;
   byte_t       wbyte;
   byte_t       ctl_read;

   // Register index match for a byte address
   function automatic logic hit(input logic [AW-1:0] addr, input logic [11:0] idx);
      hit = (addr[1:0] == 2'h0) && (addr[AW-1:2] == idx[AW-3:0]);
   endfunction

   // Address maps onto any register at all
   function automatic logic mapped(input logic [AW-1:0] addr);
      mapped = hit(addr, `IDX_TIMER_CONTROL) || hit(addr, `IDX_PIN_CONTROL) ||
               hit(addr, `IDX_MODE_SELECT)   || hit(addr, `IDX_PRESCALE)    ||
               hit(addr, `IDX_MAIN_COUNT);
   endfunction

   // ************************************************************
   // APB slave timing
   // ************************************************************
   // Setup cycle is seen at one edge, access completes at the next
   assign setup_phase = PSEL && !PENABLE;
   assign wr_take     = PSEL && PENABLE && pready_ff && PWRITE;
   assign wbyte       = PWDATA[7:0];

   // Ready raised for exactly the access cycle, zero wait states
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (CE) begin
         pready_ff  <= setup_phase;
         pslverr_ff <= setup_phase && !mapped(PADDR);
      end
   end

   // Control byte: flags, status, forced stop always reads 0
   assign ctl_read = {2'h0, under_flag_ff, edge_flag_ff, 1'b0, 1'b0,
                      status, start_ff};

   // Read data captured in setup; counters are one byte each
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         prdata_ff <= 32'h0;
      end else if (CE) begin
         if (setup_phase && !PWRITE) begin
            prdata_ff <= 32'h0;
            if (hit(PADDR, `IDX_TIMER_CONTROL)) begin
               prdata_ff[7:0] <= ctl_read;
            end
            if (hit(PADDR, `IDX_PIN_CONTROL)) begin
               prdata_ff[7:0] <= pin_ctl_ff;
            end
            if (hit(PADDR, `IDX_MODE_SELECT)) begin
               prdata_ff[7:0] <= mode_ff & 8'hf7;
            end
            if (hit(PADDR, `IDX_PRESCALE)) begin
               prdata_ff[7:0] <= presc_count;
            end
            if (hit(PADDR, `IDX_MAIN_COUNT)) begin
               prdata_ff[7:0] <= main_count;
            end
         end
      end
   end

   // ************************************************************
   // Mode and pin control registers
   // ************************************************************
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         mode_ff <= `RST_MODE_SELECT;
      end else if (CE) begin
         if (wr_take && hit(PADDR, `IDX_MODE_SELECT)) begin
            mode_ff <= wbyte & 8'hf7;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         pin_ctl_ff <= `RST_PIN_CONTROL;
      end else if (CE) begin
         if (wr_take && hit(PADDR, `IDX_PIN_CONTROL)) begin
            pin_ctl_ff <= wbyte & `PIN_STORED_MASK;
         end
      end
   end

   assign event_mode = (mode_ff[`MODE_MSB:`MODE_LSB] == `MODE_EVENT_COUNT);
   assign pulse_mode = (mode_ff[`MODE_MSB:`MODE_LSB] == `MODE_PULSE_PERIOD);

   // ************************************************************
   // Start, forced stop and status synchronisation
   // ************************************************************
   assign force_stop = wr_take && hit(PADDR, `IDX_TIMER_CONTROL) &&
                       wbyte[`CTL_STOP_BIT];

   // Forced stop wins over a start in the same write
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         start_ff <= 1'b0;
      end else if (CE) begin
         if (force_stop) begin
            start_ff <= 1'b0;
         end else if (wr_take && hit(PADDR, `IDX_TIMER_CONTROL)) begin
            start_ff <= wbyte[`CTL_START_BIT];
         end
      end
   end

   // One cycle of sync each way keeps the counters glitch free
   always_comb begin
      nxt_run = run_ff;
      case (run_ff)
         RUN_STOPPED: begin
            if (start_ff) begin
               nxt_run = RUN_START_SYNC;
            end
         end
         RUN_START_SYNC: begin
            nxt_run = start_ff ? RUN_COUNTING : RUN_STOPPED;
         end
         RUN_COUNTING: begin
            if (!start_ff) begin
               nxt_run = RUN_STOP_SYNC;
            end
         end
         RUN_STOP_SYNC: begin
            nxt_run = start_ff ? RUN_COUNTING : RUN_STOPPED;
         end
         default: begin
            nxt_run = RUN_STOPPED;
         end
      endcase
      if (force_stop) begin
         nxt_run = RUN_STOPPED;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         run_ff <= RUN_STOPPED;
      end else if (CE) begin
         run_ff <= nxt_run;
      end
   end

   // Status reads 1 while the counters run and through the stop sync cycle
   assign status   = (run_ff == RUN_COUNTING) || (run_ff == RUN_STOP_SYNC);
   assign counting = (run_ff == RUN_COUNTING);

   // ************************************************************
   // Count source: pin edge detection
   // ************************************************************
   // Pin is synchronous to CLK; only its previous level is kept
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         pin_prev_ff <= 1'b0;
      end else if (CE) begin
         pin_prev_ff <= TIMER_IO_PIN;
      end
   end

   // Polarity 0 takes rising edges, 1 falling; cutoff withholds the source
   assign pin_edge = (pin_ctl_ff[`PIN_POLARITY_BIT] ? (pin_prev_ff && !TIMER_IO_PIN)
                                                    : (!pin_prev_ff && TIMER_IO_PIN)) &&
                     counting && (event_mode || pulse_mode) && !mode_ff[`CUTOFF_BIT];

   // ************************************************************
   // Counters
   // ************************************************************
   assign wr_presc = wr_take && hit(PADDR, `IDX_PRESCALE);
   assign wr_main  = wr_take && hit(PADDR, `IDX_MAIN_COUNT);

   // Prescaler counts pin events
   reload_down_counter #(
      .WIDTH (8)
   ) u_prescale (
      .clk        (CLK),
      .rst_b      (RST_B),
      .ce         (CE),
      .force_load (force_stop),
      .force_val  (`STOP_LOAD_VALUE),
      .wr_en      (wr_presc),
      .wr_count   (!status),
      .wr_val     (wbyte),
      .dec        (pin_edge),
      .count      (presc_count),
      .underflow  (presc_under)
   );

   // Main counter counts prescaler underflows, giving the product period
   reload_down_counter #(
      .WIDTH (8)
   ) u_main (
      .clk        (CLK),
      .rst_b      (RST_B),
      .ce         (CE),
      .force_load (force_stop),
      .force_val  (`STOP_LOAD_VALUE),
      .wr_en      (wr_main),
      .wr_count   (!status),
      .wr_val     (wbyte),
      .dec        (presc_under),
      .count      (main_count),
      .underflow  (main_under)
   );

   // Interrupt request pulse on each main underflow
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         irq_ff <= 1'b0;
      end else if (CE) begin
         irq_ff <= main_under;
      end
   end

   // ************************************************************
   // Edge and underflow flags
   // ************************************************************
   // Writing 0 clears in pulse period mode; a set in the same cycle wins.
   // Event counter mode never sets them, so they stay as software left them.
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         edge_flag_ff <= 1'b0;
      end else if (CE) begin
         if (pulse_mode && presc_under) begin
            edge_flag_ff <= 1'b1;
         end else if (wr_take && hit(PADDR, `IDX_TIMER_CONTROL) && pulse_mode &&
                      !wbyte[`CTL_EDGE_BIT]) begin
            edge_flag_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         under_flag_ff <= 1'b0;
      end else if (CE) begin
         if (pulse_mode && main_under) begin
            under_flag_ff <= 1'b1;
         end else if (wr_take && hit(PADDR, `IDX_TIMER_CONTROL) && pulse_mode &&
                      !wbyte[`CTL_UNDER_BIT]) begin
            under_flag_ff <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign PRDATA    = prdata_ff;
   assign PREADY    = pready_ff;
   assign PSLVERR   = pslverr_ff;
   assign TIMER_IRQ = irq_ff;

endmodule

/* verification/evt_pulse_source.sv */
module evt_pulse_source (
   // Clock
   input  wire logic       clk,
   // Burst request
   input  wire logic       go,
   input  wire logic [8:0] n,
   // Pin side
   output logic            pin,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [8:0] left_ff;
   logic [1:0] hold_ff;

   // Each event is a full low-high-low pulse; random hold stresses edge detection
   always @(posedge clk) begin
      if (go) begin
         left_ff <= n;
         busy <= 1'b1;
         hold_ff <= 2'h0;
      end else if (busy) begin
         if (hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
         end else if (pin) begin
            pin <= 1'b0;
            hold_ff <= 2'($urandom_range(2, 0));
         end else if (left_ff != 9'h0) begin
            pin <= 1'b1;
            left_ff <= left_ff - 9'h1;
            hold_ff <= 2'($urandom_range(2, 0));
         end else begin
            busy <= 1'b0;
         end
      end
   end

   initial begin
      pin = 1'b0;
      busy = 1'b0;
   end
endmodule

/* verification/evt_timer_chk.sv */
module evt_timer_chk
   import evt_timer_pkg::*;
#(
   parameter int AW = 12
) (
   // Clock and reset
   input wire logic          CLK,
   input wire logic          RST_B,
   input wire logic          CE,
   // APB
   input wire logic          PSEL,
   input wire logic          PENABLE,
   input wire logic          PWRITE,
   input wire logic [AW-1:0] PADDR,
   input wire logic [31:0]   PWDATA,
   input wire logic [31:0]   PRDATA,
   input wire logic          PREADY,
   input wire logic          PSLVERR,
   // Timer pin
   input wire logic          TIMER_IO_PIN,
   input wire logic          TIMER_IRQ
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   // Decode of the five word registers; misaligned addresses never match
   logic mapped;
   logic rd_done;
   assign mapped = PADDR[1:0] == 2'h0 && PADDR[AW-1:2] >= 'h100 && PADDR[AW-1:2] <= 'h104;
   assign rd_done = PREADY && PSEL && PENABLE && !PWRITE;

   sequence s_setup;
      PSEL && !PENABLE && CE;
   endsequence
   sequence s_access;
      PSEL && PENABLE && PREADY;
   endsequence

   // ************************************************************
   // Assertions
   // ************************************************************
   chk_ready_setup: assert property (s_setup |=> s_access)
      else $error("no ready one cycle after setup");
   chk_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   chk_irq_pulse: assert property (TIMER_IRQ |=> !TIMER_IRQ)
      else $error("interrupt pulse too long");
   chk_err_unmapped: assert property (PSLVERR |-> PREADY && !mapped)
      else $error("error on mapped address");
   chk_err_mapped: assert property (PREADY && !mapped |-> PSLVERR)
      else $error("unmapped address not refused");
   chk_rdata_upper: assert property (rd_done |-> PRDATA[31:8] == 24'h0)
      else $error("upper read data not zero");
   chk_mode_bit3: assert property (rd_done && PADDR == 'h408 |-> !PRDATA[3])
      else $error("mode bit 3 read as one");
   chk_stop_reads0: assert property (rd_done && PADDR == 'h400 |-> !PRDATA[2])
      else $error("forced stop bit read as one");
   chk_reset_quiet: assert property (disable iff (1'b0)
      !RST_B |=> !PREADY && !TIMER_IRQ && PRDATA == 32'h0)
      else $error("outputs active after reset");
endmodule

bind event_counter_timer evt_timer_chk #(.AW(AW)) i_chk (
   .CLK(CLK), .RST_B(RST_B), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .TIMER_IO_PIN(TIMER_IO_PIN), .TIMER_IRQ(TIMER_IRQ)
);

/* verification/testbench.sv */
`include "evt_timer_map.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import evt_timer_pkg::*;

   localparam logic [11:0] A_CTL = 12'(`IDX_TIMER_CONTROL << 2);
   localparam logic [11:0] A_PIN = 12'(`IDX_PIN_CONTROL << 2);
   localparam logic [11:0] A_MODE = 12'(`IDX_MODE_SELECT << 2);
   localparam logic [11:0] A_PRE = 12'(`IDX_PRESCALE << 2);
   localparam logic [11:0] A_MAIN = 12'(`IDX_MAIN_COUNT << 2);

   typedef struct {logic [11:0] a; logic [32:0] v;} note_t;

   logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, pin, src_go = 1'b0, src_busy;
   logic [8:0]  src_n = 9'h0;
   note_t       notes[$];
   note_t       got_n;
   int          bad_count = 0, checks = 0, cycles = 0, irq_seen = 0, irq_base = 0, n;
   logic [7:0]  p, m, v;
   logic [7:0]  v_list[2] = '{8'h82, 8'h00};

   always #12.5 clk = ~clk;

   event_counter_timer #(.AW(12)) i_dut (
      .CLK(clk), .RST_B(rst_b), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TIMER_IO_PIN(pin), .TIMER_IRQ(irq)
   );
   evt_pulse_source i_src (.clk(clk), .go(src_go), .n(src_n), .pin(pin), .busy(src_busy));

   // ************************************************************
   // Tasks
   // ************************************************************
   task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      checks++;
      if (e !== g) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task tally_and_finish();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Request held until ready is sampled high, then released
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [11:0] a, input logic [7:0] d, input logic e = 1'b0);
      notes.push_back('{a, {e, 24'h0, d}});
      apb(1'b0, a, 8'h0);
   endtask

   task send(input int k);
      src_n <= 9'(k);
      src_go <= 1'b1;
      @(posedge clk);
      src_go <= 1'b0;
      @(posedge clk);
      while (src_busy) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask

   // ************************************************************
   // Monitors and sequence
   // ************************************************************
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         got_n = notes.pop_front();
         chk($sformatf("read %h", got_n.a), got_n.v, {pslverr, prdata});
      end
      if (irq === 1'b1) irq_seen <= irq_seen + 1;
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   initial begin
      void'($urandom(32'h27c0));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(A_CTL, 8'h00);
      rd(A_MODE, 8'h00);
      rd(A_PRE, 8'hff);
      rd(A_MAIN, 8'hff);
      rd(12'h414, 8'h00, 1'b1);
      rd(12'h409, 8'h00, 1'b1);
      wr(A_MODE, 8'hff);
      rd(A_MODE, 8'hf7);
      wr(A_MODE, 8'h02);
      wr(A_PIN, 8'hff);
      rd(A_PIN, 8'h3f);
      wr(A_PIN, 8'h00);
      $display("test reset done");
      // Boundary 0/0 first, then random loads
      for (int it = 0; it < 3; it++) begin
         p = (it == 0) ? 8'h0 : 8'($urandom_range(3, 0));
         m = (it == 0) ? 8'h0 : 8'($urandom_range(3, 0));
         n = (p + 1) * (m + 1);
         // Last pass counts falling edges to cover the other polarity
         wr(A_PIN, (it == 2) ? 8'h01 : 8'h00);
         wr(A_PRE, p);
         wr(A_MAIN, m);
         rd(A_PRE, p);
         rd(A_MAIN, m);
         wr(A_CTL, 8'h01);
         repeat (3) @(posedge clk);
         rd(A_CTL, 8'h03);
         irq_base = irq_seen;
         send(n - 1);
         chk("early irq", 33'h0, 33'(irq_seen - irq_base));
         send(1);
         chk("irq", 33'h1, 33'(irq_seen - irq_base));
         send(n);
         chk("reload irq", 33'h2, 33'(irq_seen - irq_base));
         wr(A_CTL, 8'h00);
         repeat (3) @(posedge clk);
         rd(A_CTL, 8'h00);
         rd(A_PRE, p);
         rd(A_MAIN, m);
      end
      $display("test count done");
      // Cutoff bit and a foreign mode must both block counting
      foreach (v_list[i]) begin
         wr(A_MODE, v_list[i]);
         wr(A_CTL, 8'h01);
         repeat (3) @(posedge clk);
         irq_base = irq_seen;
         send(n);
         chk("gated irq", 33'h0, 33'(irq_seen - irq_base));
         wr(A_CTL, 8'h00);
         repeat (3) @(posedge clk);
         rd(A_MAIN, m);
      end
      // Clock enable low must freeze counting while events arrive
      wr(A_MODE, 8'h02);
      wr(A_CTL, 8'h01);
      repeat (3) @(posedge clk);
      irq_base = irq_seen;
      ce <= 1'b0;
      send(n);
      ce <= 1'b1;
      @(posedge clk);
      chk("frozen irq", 33'h0, 33'(irq_seen - irq_base));
      rd(A_PRE, p);
      rd(A_MAIN, m);
      $display("test gate done");
      send(1);
      wr(A_CTL, 8'h05);
      rd(A_CTL, 8'h00);
      rd(A_PRE, 8'hff);
      rd(A_MAIN, 8'hff);
      $display("test stop done");
      // Pulse period mode: one event sets both flags, writing 0 clears one
      wr(A_MODE, 8'h03);
      wr(A_CTL, 8'h00);
      wr(A_PRE, 8'h00);
      wr(A_MAIN, 8'h00);
      wr(A_CTL, 8'h01);
      repeat (3) @(posedge clk);
      send(1);
      rd(A_CTL, 8'h33);
      wr(A_CTL, 8'h21);
      rd(A_CTL, 8'h23);
      wr(A_CTL, 8'h00);
      repeat (3) @(posedge clk);
      rd(A_CTL, 8'h00);
      $display("test flags done");
      tally_and_finish();
   end
endmodule
